// file: src/dmr_pkg.sv
// Constants and types shared by the request channel controller
package dmr_pkg;
  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NUM_CH    = 7;
  localparam int CH_W      = 3;
  localparam int CNT_W     = 16;
  localparam int ADDR_W    = 32;
  localparam int DATA_W    = 32;
  localparam int RA_W      = 8;
  localparam int NUM_EV    = 3;
  localparam int EV_STRIDE = 4;
  localparam int CFG_W     = 8;
  localparam int ST_W      = EV_STRIDE * NUM_CH;
  // ----------------------------------------
  // Register offsets; channel n block at 8'h10 * (n + 1)
  // ----------------------------------------
  localparam logic [RA_W-1:0] OFF_STATUS = 8'h00;
  localparam logic [RA_W-1:0] OFF_MASK   = 8'h04;
  localparam logic [RA_W-1:0] OFF_SWTRIG = 8'h08;
  localparam logic [RA_W-1:0] OFF_SYSCFG = 8'h0C;
  localparam logic [3:0]      SUB_CFG    = 4'h0;
  localparam logic [3:0]      SUB_CNT    = 4'h4;
  localparam logic [3:0]      SUB_PADDR  = 4'h8;
  localparam logic [3:0]      SUB_MADDR  = 4'hC;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CFG_EN   = 0;
  localparam int CFG_DIR  = 1;
  localparam int CFG_CIRC = 3;
  localparam int CFG_PRI  = 4;
  localparam int CFG_PINC = 6;
  localparam int CFG_MINC = 7;
  localparam int EV_HT    = 0;
  localparam int EV_TC    = 1;
  localparam int EV_TE    = 2;
  localparam int SYS_TMR2 = 8;
  localparam int SYS_W    = SYS_TMR2 + NUM_CH;
  // ----------------------------------------
  // Values
  // ----------------------------------------
  localparam logic [ST_W-1:0]   EV_BITS   = 28'h7777777;
  localparam logic [CFG_W-1:0]  RST_CFG   = 8'h00;
  localparam logic [CNT_W-1:0]  RST_CNT   = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_ONE   = 16'h0001;
  localparam logic [ADDR_W-1:0] RST_ADDR  = 32'h00000000;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 32'h00000004;
  localparam logic [SYS_W-1:0]  RST_SYS   = 15'h0000;
  typedef enum logic [1:0] {DIR_P2M, DIR_M2P, DIR_M2M, DIR_RSVD} dmr_dir_t;
  typedef enum logic [1:0] {PRI_LOW, PRI_MED, PRI_HIGH, PRI_TOP} dmr_pri_t;
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE, ST_ACK} dmr_state_t;
endpackage

// file: src/dmr_arbiter.sv
// Two-stage channel arbiter: software level, then channel number
`timescale 1ns/100ps
module dmr_arbiter import dmr_pkg::*; #(
  parameter int NCH = NUM_CH,
  parameter int IW  = CH_W
) (
  // Requests and levels
  input  wire logic [NCH-1:0]   req,
  input  wire logic [2*NCH-1:0] pri,
  // Winner
  output logic                  grantValid,
  output logic [IW-1:0]         grantIdx
);
  logic          found;
  logic [1:0]    bestPri;
  logic [IW-1:0] idx;

  // Scan downward so a lower channel overwrites on a tie
  always_comb begin
    found   = 1'b0;
    bestPri = 2'h0;
    idx     = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (req[i] && (!found || pri[2*i +: 2] >= bestPri)) begin
        found   = 1'b1;
        bestPri = pri[2*i +: 2];
        idx     = IW'(i);
      end
    end
  end

  assign grantValid = found;
  assign grantIdx   = idx;
endmodule

// file: src/dmr_event_flags.sv
// Sticky event flags of one channel with per-flag interrupt gating
`timescale 1ns/100ps
module dmr_event_flags import dmr_pkg::*; #(
  parameter int NEV = NUM_EV
) (
  // Clock and reset
  input  wire logic           core_clk,
  input  wire logic           rst_b,
  // Set and clear
  input  wire logic [NEV-1:0] hwSet,
  input  wire logic [NEV-1:0] swSet,
  input  wire logic           clrAll,
  // Gating and results
  input  wire logic [NEV-1:0] enable,
  output logic [NEV-1:0]      flags,
  output logic [NEV-1:0]      irqs
);
  logic [NEV-1:0] flagsQ;
  logic [NEV-1:0] flagsD;

  // Set wins over a clear in the same cycle so no event is lost
  assign flagsD = (flagsQ & ~{NEV{clrAll}}) | hwSet | swSet;
  assign flags  = flagsQ;
  assign irqs   = flagsQ & enable;

  // Flag storage
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      flagsQ <= '0;
    end else begin
      flagsQ <= flagsD;
    end
  end
endmodule

// file: src/dmr_top.sv
// Seven-channel request controller with routing, arbitration and transfer engine
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/100ps
module dmr_top import dmr_pkg::*; (
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     rst_b,
  // Register port
  input  wire logic [RA_W-1:0]          regAddr,
  input  wire logic [31:0]              regWdata,
  input  wire logic                     regWr,
  input  wire logic                     regRd,
  output logic [31:0]                   regRdata,
  // Peripheral request lines, one bit per channel
  input  wire logic [NUM_CH-1:0]        reqPlain,
  input  wire logic [NUM_CH-1:0]        reqDefault,
  input  wire logic [NUM_CH-1:0]        reqAlt,
  input  wire logic [NUM_CH-1:0]        reqThird,
  output logic [NUM_CH-1:0]             reqAck,
  // System memory bus
  output logic                          memValid,
  output logic                          memWrite,
  output logic [ADDR_W-1:0]             memAddr,
  output logic [DATA_W-1:0]             memWdata,
  input  wire logic [DATA_W-1:0]        memRdata,
  input  wire logic                     memReady,
  input  wire logic                     memErr,
  // Interrupts
  output logic [NUM_EV*NUM_CH-1:0]      eventIrq,
  output logic                          irq
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [CFG_W-1:0]  cfgQ    [NUM_CH];
  logic [CNT_W-1:0]  cntQ    [NUM_CH];
  logic [CNT_W-1:0]  baseCntQ[NUM_CH];
  logic [ADDR_W-1:0] pCurQ   [NUM_CH];
  logic [ADDR_W-1:0] pBaseQ  [NUM_CH];
  logic [ADDR_W-1:0] mCurQ   [NUM_CH];
  logic [ADDR_W-1:0] mBaseQ  [NUM_CH];
  logic [SYS_W-1:0]  sysCfgQ;
  logic [ST_W-1:0]   maskQ;
  logic [31:0]       rdataQ;
  logic [DATA_W-1:0] dataQ;
  logic [CH_W-1:0]   chanQ;
  dmr_state_t        stateQ;
  dmr_state_t        stateD;

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  logic [CH_W-1:0] chField;
  logic [CH_W-1:0] chIdx;
  logic [3:0]      subOff;
  logic            isChan;
  logic            chWr;
  logic            statusRd;
  logic            maskWr;
  logic            swWr;
  logic            sysWr;
  logic [ST_W-1:0] swBits;

  // Channel blocks sit at 8'h10..8'h70; the top half of the map is unmapped
  assign chField  = regAddr[6:4];
  assign chIdx    = chField - 3'h1;
  assign subOff   = regAddr[3:0];
  assign isChan   = !regAddr[7] && (chField != 3'h0);
  assign chWr     = regWr && isChan;
  assign statusRd = regRd && (regAddr == OFF_STATUS);
  assign maskWr   = regWr && (regAddr == OFF_MASK);
  assign swWr     = regWr && (regAddr == OFF_SWTRIG);
  assign sysWr    = regWr && (regAddr == OFF_SYSCFG);
  assign swBits   = regWdata[ST_W-1:0] & EV_BITS;

  // ----------------------------------------
  // Request routing
  // ----------------------------------------
  logic [NUM_CH-1:0]   remapBits;
  logic [NUM_CH-1:0]   tmr2Bits;
  logic [NUM_CH-1:0]   routedReq;
  logic [NUM_CH-1:0]   chanReq;
  logic [2*NUM_CH-1:0] priVec;

  // Remap bits pick which source group feeds each channel
  assign remapBits = sysCfgQ[NUM_CH-1:0];
  assign tmr2Bits  = sysCfgQ[SYS_TMR2 +: NUM_CH];
  assign routedReq = reqPlain
                   | (reqDefault & ~remapBits)
                   | (reqAlt & remapBits)
                   | (reqThird & tmr2Bits);

  // A channel asks for service while enabled with items left and its routed line high; a memory-to-memory channel needs no line
  for (genvar g = 0; g < NUM_CH; g++) begin : g_req
    logic gM2m;
    assign gM2m = dmr_dir_t'(cfgQ[g][CFG_DIR +: 2]) == DIR_M2M;
    assign chanReq[g] = cfgQ[g][CFG_EN] && (cntQ[g] != RST_CNT) && (gM2m || routedReq[g]);
    assign priVec[2*g +: 2] = cfgQ[g][CFG_PRI +: 2];
  end

  // ----------------------------------------
  // Arbitration
  // ----------------------------------------
  logic            grantValid;
  logic [CH_W-1:0] grantIdx;

  dmr_arbiter #(
    .NCH (NUM_CH),
    .IW  (CH_W)
  ) u_arb (
    .req        (chanReq),
    .pri        (priVec),
    .grantValid (grantValid),
    .grantIdx   (grantIdx)
  );

  // ----------------------------------------
  // Transfer engine
  // ----------------------------------------
  logic [CFG_W-1:0]  curCfg;
  dmr_dir_t          curDir;
  logic [CNT_W-1:0]  curCnt;
  logic [CNT_W-1:0]  curBase;
  logic [ADDR_W-1:0] srcAddr;
  logic [ADDR_W-1:0] dstAddr;
  logic              itemDone;
  logic              itemFail;
  logic              lastItem;
  logic              halfHit;
  logic [CNT_W-1:0]  cntLess;

  // Only the memory-to-peripheral direction reads through the memory pointer
  assign curCfg   = cfgQ[chanQ];
  assign curDir   = dmr_dir_t'(curCfg[CFG_DIR +: 2]);
  assign curCnt   = cntQ[chanQ];
  assign curBase  = baseCntQ[chanQ];
  assign srcAddr  = (curDir == DIR_M2P) ? mCurQ[chanQ] : pCurQ[chanQ];
  assign dstAddr  = (curDir == DIR_M2P) ? pCurQ[chanQ] : mCurQ[chanQ];
  assign cntLess  = curCnt - CNT_ONE;
  assign lastItem = curCnt == CNT_ONE;
  assign halfHit  = cntLess == (curBase >> 1);
  assign itemDone = (stateQ == ST_WRITE) && memReady && !memErr;
  assign itemFail = ((stateQ == ST_READ) || (stateQ == ST_WRITE)) && memReady && memErr;

  // Bus outputs; address and data come straight from registers
  assign memValid = (stateQ == ST_READ) || (stateQ == ST_WRITE);
  assign memWrite = stateQ == ST_WRITE;
  assign memAddr  = (stateQ == ST_WRITE) ? dstAddr : srcAddr;
  assign memWdata = dataQ;

  // Next state: one item is a read, a write and an acknowledge cycle
  always_comb begin
    stateD = stateQ;
    unique case (stateQ)
      ST_IDLE:  if (grantValid) stateD = ST_READ;
      ST_READ:  if (memReady) stateD = memErr ? ST_IDLE : ST_WRITE;
      ST_WRITE: if (memReady) stateD = memErr ? ST_IDLE : ST_ACK;
      ST_ACK:   stateD = ST_IDLE;
    endcase
  end

  // Engine registers; the channel is held for the whole item
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      stateQ <= ST_IDLE;
      chanQ  <= '0;
      dataQ  <= '0;
    end else begin
      stateQ <= stateD;
      if (stateQ == ST_IDLE) chanQ <= grantIdx;
      if (stateQ == ST_READ && memReady) dataQ <= memRdata;
    end
  end

  // The acknowledge cycle lets the source drop its line before re-arbitration
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ack
    assign reqAck[g] = (stateQ == ST_ACK) && (chanQ == CH_W'(g));
  end

  // ----------------------------------------
  // Channel registers
  // ----------------------------------------
  // Software writes load base and live values; engine updates follow and win
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < NUM_CH; i++) begin
      if (!rst_b) begin
        cfgQ[i] <= RST_CFG;
        cntQ[i] <= RST_CNT;
        baseCntQ[i] <= RST_CNT;
        pCurQ[i] <= RST_ADDR;
        pBaseQ[i] <= RST_ADDR;
        mCurQ[i] <= RST_ADDR;
        mBaseQ[i] <= RST_ADDR;
      end else begin
        if (chWr && chIdx == CH_W'(i)) begin
          unique case (subOff)
            SUB_CFG: cfgQ[i] <= regWdata[CFG_W-1:0];
            SUB_CNT: begin
              cntQ[i] <= regWdata[CNT_W-1:0];
              baseCntQ[i] <= regWdata[CNT_W-1:0];
            end
            SUB_PADDR: begin
              pCurQ[i] <= regWdata;
              pBaseQ[i] <= regWdata;
            end
            SUB_MADDR: begin
              mCurQ[i] <= regWdata;
              mBaseQ[i] <= regWdata;
            end
            default: ;
          endcase
        end
        if (itemDone && chanQ == CH_W'(i)) begin
          if (lastItem && cfgQ[i][CFG_CIRC]) begin
            cntQ[i] <= baseCntQ[i];
            pCurQ[i] <= pBaseQ[i];
            mCurQ[i] <= mBaseQ[i];
          end else begin
            cntQ[i] <= cntLess;
            if (lastItem) cfgQ[i][CFG_EN] <= 1'b0;
            if (!lastItem && cfgQ[i][CFG_PINC]) pCurQ[i] <= pCurQ[i] + ADDR_STEP;
            if (!lastItem && cfgQ[i][CFG_MINC]) mCurQ[i] <= mCurQ[i] + ADDR_STEP;
          end
        end
        if (itemFail && chanQ == CH_W'(i)) cfgQ[i][CFG_EN] <= 1'b0;
      end
    end
  end

  // Global configuration registers
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      sysCfgQ <= RST_SYS;
      maskQ   <= '0;
    end else begin
      if (sysWr) sysCfgQ <= regWdata[SYS_W-1:0];
      if (maskWr) maskQ <= swBits;
    end
  end

  // ----------------------------------------
  // Event flags
  // ----------------------------------------
  logic [ST_W-1:0] flagsAll;

  for (genvar g = 0; g < NUM_CH; g++) begin : g_ev
    logic [NUM_EV-1:0] hw;
    logic [NUM_EV-1:0] fl;
    logic              mine;
    assign mine = chanQ == CH_W'(g);
    assign hw[EV_HT] = itemDone && mine && halfHit;
    assign hw[EV_TC] = itemDone && mine && lastItem;
    assign hw[EV_TE] = itemFail && mine;
    assign flagsAll[EV_STRIDE*g +: EV_STRIDE] = {1'b0, fl};
    dmr_event_flags #(
      .NEV (NUM_EV)
    ) u_flags (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .hwSet    (hw),
      .swSet    (swWr ? swBits[EV_STRIDE*g +: NUM_EV] : 3'h0),
      .clrAll   (statusRd),
      .enable   (maskQ[EV_STRIDE*g +: NUM_EV]),
      .flags    (fl),
      .irqs     (eventIrq[NUM_EV*g +: NUM_EV])
    );
  end

  assign irq = |eventIrq;

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  logic [31:0] chanWord;
  logic [31:0] rdWord;

  // Unmapped offsets and write-only triggers read as zero
  assign chanWord = (subOff == SUB_CFG)   ? {24'h000000, cfgQ[chIdx]} :
                    (subOff == SUB_CNT)   ? {16'h0000, cntQ[chIdx]} :
                    (subOff == SUB_PADDR) ? pCurQ[chIdx] :
                    (subOff == SUB_MADDR) ? mCurQ[chIdx] : 32'h00000000;
  assign rdWord   = isChan                    ? chanWord :
                    (regAddr == OFF_STATUS)   ? {4'h0, flagsAll} :
                    (regAddr == OFF_MASK)     ? {4'h0, maskQ} :
                    (regAddr == OFF_SYSCFG)   ? {17'h00000, sysCfgQ} : 32'h00000000;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rdataQ <= 32'h00000000;
    end else begin
      rdataQ <= regRd ? rdWord : 32'h00000000;
    end
  end

  assign regRdata = rdataQ;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic              arbOk;
  logic [1:0]        gPri;
  logic [NUM_EV-1:0] curFlags;

  // No requester beats the winner on level, or on number at equal level
  assign gPri     = priVec[2*grantIdx +: 2];
  assign curFlags = flagsAll[EV_STRIDE*chanQ +: NUM_EV];
  always_comb begin
    arbOk = grantValid;
    for (int i = 0; i < NUM_CH; i++) begin
      if (chanReq[i] && (priVec[2*i +: 2] > gPri || (priVec[2*i +: 2] == gPri && CH_W'(i) < grantIdx))) arbOk = 1'b0;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  arb_order_a: assert property ((stateQ == ST_IDLE && grantValid) |-> arbOk ##1
    (stateQ == ST_READ && chanQ == $past(grantIdx))) else $error("wrong channel granted");
  chan_hold_a: assert property ((stateQ != ST_IDLE) |=> $stable(chanQ))
    else $error("channel changed mid item");
  count_dec_a: assert property ((itemDone && !lastItem) |=> curCnt == $past(curCnt) - CNT_ONE)
    else $error("count not decremented");
  circ_reload_a: assert property ((itemDone && lastItem && curCfg[CFG_CIRC]) |=>
    (curCnt == $past(curBase) && curCfg[CFG_EN])) else $error("circular reload missing");
  block_stop_a: assert property ((itemDone && lastItem && !curCfg[CFG_CIRC]) |=>
    (!curCfg[CFG_EN] && curCnt == RST_CNT)) else $error("channel did not stop");
  tc_flag_a: assert property ((itemDone && lastItem) |=> curFlags[EV_TC])
    else $error("complete flag not set");
  half_flag_a: assert property ((itemDone && halfHit) |=> curFlags[EV_HT])
    else $error("half flag not set");
  err_stop_a: assert property (itemFail |=> (!curCfg[CFG_EN] && curFlags[EV_TE] && stateQ == ST_IDLE))
    else $error("error not handled");
  ack_once_a: assert property ((reqAck != 0) |-> ($onehot(reqAck) && $past(stateQ) == ST_WRITE) ##1
    (reqAck == 0)) else $error("acknowledge not single");
  sw_trig_a: assert property (swWr |=> (flagsAll & $past(swBits)) == $past(swBits))
    else $error("software trigger lost");
  irq_hold_a: assert property ((irq && !statusRd && !maskWr) |=> irq)
    else $error("interrupt dropped");

  circ_c: cover property (itemDone && lastItem && curCfg[CFG_CIRC]);
  err_c: cover property (itemFail);
  m2m_c: cover property (itemDone && curDir == DIR_M2M);
  contend_c: cover property (stateQ == ST_IDLE && $countones(chanReq) > 1);
endmodule

// file: tb/dmr_mem_model.sv
// Behavioural system memory with stall and error injection
`timescale 1ns/100ps
module dmr_mem_model import dmr_pkg::*; #(
  parameter logic [DATA_W-1:0] RD_KEY = 32'h5A5A0000
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  // Controller bus
  input  wire logic              memValid,
  input  wire logic              memWrite,
  input  wire logic [ADDR_W-1:0] memAddr,
  input  wire logic [DATA_W-1:0] memWdata,
  output logic [DATA_W-1:0]      memRdata,
  output logic                   memReady,
  output logic                   memErr,
  // Test control and record
  input  wire logic [3:0]        waitCycles,
  input  wire logic [ADDR_W-1:0] errAddr,
  output logic [7:0]             wrCount,
  output logic [ADDR_W-1:0]      lastWrAddr,
  output logic [DATA_W-1:0]      lastWrData
);
  logic [3:0] waitCnt;
  // Answer after waitCycles; data flips outside answers so stale data never matches
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      memReady <= 1'b0;
      memErr <= 1'b0;
      memRdata <= 32'h00000000;
      waitCnt <= 4'h0;
      wrCount <= 8'h00;
      lastWrAddr <= 32'h00000000;
      lastWrData <= 32'h00000000;
    end else if (memValid && !memReady && waitCnt >= waitCycles) begin
      memReady <= 1'b1;
      memErr <= (memAddr == errAddr);
      memRdata <= memAddr ^ RD_KEY;
      waitCnt <= 4'h0;
    end else begin
      memReady <= 1'b0;
      memErr <= 1'b0;
      memRdata <= ~memRdata;
      if (memValid && !memReady) waitCnt <= waitCnt + 4'h1;
    end
    // Record completed writes for the bench
    if (rst_b && memValid && memReady && memWrite) begin
      wrCount <= wrCount + 8'h01;
      lastWrAddr <= memAddr;
      lastWrData <= memWdata;
    end
  end
endmodule

// file: tb/tb.sv
// Self-checking bench for the request channel controller
`timescale 1ns/100ps
module tb import dmr_pkg::*;;
  localparam logic [31:0] KEY = 32'h5A5A0000;
  logic core_clk, rst_b, regWr, regRd, memValid, memWrite, memReady, memErr, irq;
  logic [RA_W-1:0] regAddr;
  logic [31:0] regWdata, regRdata, rdVal;
  logic [NUM_CH-1:0] reqPlain, reqDefault, reqAlt, reqThird, reqAck;
  logic [ADDR_W-1:0] memAddr, errAddr, lastWrAddr;
  logic [DATA_W-1:0] memWdata, memRdata, lastWrData;
  logic [NUM_EV*NUM_CH-1:0] eventIrq;
  logic [3:0] waitCycles;
  logic [7:0] wrCount;
  int err_count, check_count;

  dmr_top dmr_top_i (.core_clk(core_clk), .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .reqPlain(reqPlain), .reqDefault(reqDefault),
    .reqAlt(reqAlt), .reqThird(reqThird), .reqAck(reqAck), .memValid(memValid), .memWrite(memWrite),
    .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata), .memReady(memReady),
    .memErr(memErr), .eventIrq(eventIrq), .irq(irq));
  dmr_mem_model #(.RD_KEY(KEY)) dmr_mem_model_i (.core_clk(core_clk), .rst_b(rst_b),
    .memValid(memValid), .memWrite(memWrite), .memAddr(memAddr), .memWdata(memWdata),
    .memRdata(memRdata), .memReady(memReady), .memErr(memErr), .waitCycles(waitCycles),
    .errAddr(errAddr), .wrCount(wrCount), .lastWrAddr(lastWrAddr), .lastWrData(lastWrData));

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe
  task rdChk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    @(posedge core_clk);
    rdVal = regRdata;
    chk(rdVal, exp);
  endtask
  function automatic logic [7:0] chA(input int ch, input logic [3:0] sub);
    return 8'(16 * (ch + 1)) | {4'h0, sub};
  endfunction
  // Config word last, so the channel starts only once fully set
  task setup(input int ch, input logic [7:0] cfg, input logic [15:0] cnt, input logic [31:0] pa, ma);
    wr(chA(ch, SUB_CNT), {16'h0000, cnt});
    wr(chA(ch, SUB_PADDR), pa);
    wr(chA(ch, SUB_MADDR), ma);
    wr(chA(ch, SUB_CFG), {24'h000000, cfg});
  endtask
  // Plain request lines are held until acknowledged, then dropped at that edge
  task waitAck(input logic [6:0] exp);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 40 && !hit; i++) begin
      @(posedge core_clk);
      if (reqAck !== 7'h00) begin
        hit = 1'b1;
        chk(32'(reqAck), 32'(exp));
        reqPlain <= reqPlain & ~reqAck;
      end
    end
    if (!hit) chk(32'h0, 32'(exp));
  endtask
  task item(input logic [6:0] v, input logic [6:0] exp);
    @(posedge core_clk);
    reqPlain <= reqPlain | v;
    waitAck(exp);
  endtask
  task results;
    $display("Checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Whole run needs a few hundred cycles
  initial begin
    #200000;
    err_count++;
    results();
  end
  initial begin
    logic [31:0] sys;
    logic        expAck;
    rst_b = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWdata = 32'h0;
    {reqPlain, reqDefault, reqAlt, reqThird} = 28'h0;
    waitCycles = 4'h0;
    errAddr = 32'h00000500;
    err_count = 0;
    check_count = 0;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    rdChk(OFF_STATUS, 32'h0);
    rdChk(8'h80, 32'h0);
    chk(32'(irq), 32'h0);
    // Largest count, distinct per channel
    for (int c = 0; c < 7; c++) wr(chA(c, SUB_CNT), 32'h0000FFFF - 32'(c));
    for (int c = 0; c < 7; c++) rdChk(chA(c, SUB_CNT), 32'h0000FFFF - 32'(c));
    // Memory to memory under a stalling bus
    waitCycles <= 4'h2;
    setup(2, 8'hC5, 16'h2, 32'h100, 32'h200);
    for (int i = 0; i < 200 && wrCount < 8'h02; i++) @(posedge core_clk);
    repeat (4) @(posedge core_clk);
    chk(lastWrAddr, 32'h204);
    chk(lastWrData, 32'h104 ^ KEY);
    rdChk(OFF_STATUS, 32'h300);
    rdChk(chA(2, SUB_CFG), 32'hC4);
    waitCycles <= 4'h0;
    // Priority first, then lower channel among equals; channel 3 runs memory to peripheral
    setup(3, 8'h03, 16'h1, 32'h80, 32'h90);
    setup(5, 8'h21, 16'h1, 32'h0, 32'h0);
    item(7'h28, 7'h20);
    item(7'h00, 7'h08);
    chk(lastWrAddr, 32'h80);
    chk(lastWrData, 32'h90 ^ KEY);
    setup(4, 8'h31, 16'h1, 32'h0, 32'h0);
    setup(6, 8'h31, 16'h1, 32'h0, 32'h0);
    item(7'h50, 7'h10);
    item(7'h00, 7'h40);
    // Each routed source, its select bit (remap, or tmr2 for reqThird) clear then set; one line live at a time
    for (int i = 0; i < 6; i++) begin
      sys = i[0] ? ((i >= 4) ? 32'h200 : 32'h2) : 32'h0;
      expAck = (i < 2) ? !i[0] : i[0];
      wr(OFF_SYSCFG, sys);
      setup(1, 8'h01, 16'h1, 32'h0, 32'h300);
      @(posedge core_clk);
      case (i / 2)
        0: reqDefault[1] <= 1'b1;
        1: reqAlt[1] <= 1'b1;
        default: reqThird[1] <= 1'b1;
      endcase
      waitAck(expAck ? 7'h02 : 7'h00);
      @(posedge core_clk);
      {reqDefault, reqAlt, reqThird} <= 21'h0;
      wr(chA(1, SUB_CFG), 32'h0);
    end
    // Circular: third item lands on the reloaded base
    setup(0, 8'h89, 16'h2, 32'h40, 32'h400);
    for (int k = 0; k < 3; k++) begin
      item(7'h01, 7'h01);
      chk(lastWrAddr, 32'h400 + 32'(4 * (k % 2)));
    end
    rdChk(chA(0, SUB_CNT), 32'h1);
    wr(chA(0, SUB_CFG), 32'h0);
    // Bus error on a masked-in error flag
    // Every single-item block so far raised half and complete together
    rdChk(OFF_STATUS, 32'h03333033);
    wr(OFF_MASK, 32'h04000000);
    setup(6, 8'h45, 16'h1, 32'h500, 32'h600);
    for (int i = 0; i < 50 && irq !== 1'b1; i++) @(posedge core_clk);
    chk(32'(eventIrq), 32'h00100000);
    rdChk(OFF_STATUS, 32'h04000000);
    chk(32'(irq), 32'h0);
    rdChk(chA(6, SUB_CFG), 32'h44);
    // Software sets all three kinds; masked first
    wr(OFF_SWTRIG, 32'h00001007);
    @(posedge core_clk);
    chk(32'(irq), 32'h0);
    wr(OFF_MASK, 32'h00001007);
    @(posedge core_clk);
    chk(32'(eventIrq), 32'h00000207);
    rdChk(OFF_STATUS, 32'h00001007);
    chk(32'(irq), 32'h0);
    results();
  end
endmodule
